// ===== src/dac_load_regs_pkg.sv
// Package: register map, field layout and reset values of the load register bank
package dac_load_regs_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] STROBE_MASK_REGISTER_OFS  = 8'h37;
    localparam logic [7:0] CHANNEL_OUTPUT_CODE_OFS   = 8'h38;
    localparam logic [7:0] OUTPUT_PAGE_BROADCAST_OFS = 8'h3E;
    localparam logic [7:0] PAGE_CHANNEL_SELECT_OFS   = 8'h41;
    localparam logic [7:0] INPUT_PAGE_BROADCAST_OFS  = 8'h42;
    localparam logic [7:0] SOFTWARE_LOAD_TRIGGER_OFS = 8'h45;
    localparam logic [7:0] CHANNEL_INPUT_CODE_OFS    = 8'h46;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int CODE_MSB     = 23;
    localparam int CODE_LSB     = 8;
    localparam int CODE_W       = CODE_MSB - CODE_LSB + 1;
    localparam int REG_W        = 24;
    localparam int CTRL_BIT     = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic        BIT_RESET  = 1'h0;
    localparam logic [23:0] READ_ZERO  = 24'h000000;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  addr;
        logic [23:0] wdata;
    } reg_req_s;

endpackage

// ===== src/precision_dac_load_regs.sv
// Precision-mode page, input and output code registers with load triggers
// Operation
// - Select set: input page write copies to input
// - Select set: output page write copies to output
// - Input page holds code in bits 23:8
// - Soft load one moves input to output
// - Soft load bit clears itself after write
// - Soft load equals hardware strobe low pulse
// - Input code bits 23:8, low byte zero
// - Three triggers move input to output
// - Reset clears page, input, select, trigger
// - Internal reset held until supplies good
// - Reserved bits 23:1 read zero
// - Mask bit clear lets strobe load output
// - Output code readable, writable, resets zero
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps

module precision_dac_load_regs (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        supply_good_i,
    input  wire logic        load_strobe_n_i,
    input  wire logic        auto_transfer_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [23:0] wdata_i,
    input  wire logic        write_i,
    input  wire logic        read_i,
    output logic      [23:0] rdata_o,
    output logic      [15:0] live_output_code_o
);

    // ------------------------------------------------------------------
    // Reset release, gated by the supply monitor
    // ------------------------------------------------------------------
    logic       rst_meta;
    logic       rst_sync;
    logic       supply_meta;
    logic       supply_sync;

    // Supply status is asynchronous; synchronise before it gates anything
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            supply_meta <= 1'b0;
            supply_sync <= 1'b0;
        end else begin
            supply_meta <= supply_good_i;
            supply_sync <= supply_meta;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta & supply_sync;
        end
    end

    logic       resetn;
    assign resetn = rst_sync;

    // ------------------------------------------------------------------
    // Bus request
    // ------------------------------------------------------------------
    dac_load_regs_pkg::reg_req_s req;
    assign req.write = write_i;
    assign req.read  = read_i;
    assign req.addr  = addr_i;
    assign req.wdata = wdata_i;

    logic [15:0] wcode;
    assign wcode = req.wdata[dac_load_regs_pkg::CODE_MSB:dac_load_regs_pkg::CODE_LSB];

    function automatic logic wr_at(input logic [7:0] ofs);
        wr_at = req.write && (req.addr == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Strobe pin, synchronised, falling edge detected
    // ------------------------------------------------------------------
    logic       strobe_meta;
    logic       strobe_sync;
    logic       strobe_prev;
    logic       auto_meta;
    logic       auto_sync;

    always_ff @(posedge clk_i or negedge resetn) begin
        if (!resetn) begin
            strobe_meta <= 1'b1;
            strobe_sync <= 1'b1;
            strobe_prev <= 1'b1;
            auto_meta   <= 1'b0;
            auto_sync   <= 1'b0;
        end else begin
            strobe_meta <= load_strobe_n_i;
            strobe_sync <= strobe_meta;
            strobe_prev <= strobe_sync;
            auto_meta   <= auto_transfer_i;
            auto_sync   <= auto_meta;
        end
    end

    // ------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------
    logic       first_channel_pick;
    logic       strobe_mask_bit;

    // Only bit 0 is stored, so reserved bits cannot be set
    always_ff @(posedge clk_i or negedge resetn) begin
        if (!resetn) begin
            first_channel_pick <= dac_load_regs_pkg::BIT_RESET;
        end else if (wr_at(dac_load_regs_pkg::PAGE_CHANNEL_SELECT_OFS)) begin
            first_channel_pick <= req.wdata[dac_load_regs_pkg::CTRL_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge resetn) begin
        if (!resetn) begin
            strobe_mask_bit <= dac_load_regs_pkg::BIT_RESET;
        end else if (wr_at(dac_load_regs_pkg::STROBE_MASK_REGISTER_OFS)) begin
            strobe_mask_bit <= req.wdata[dac_load_regs_pkg::CTRL_BIT];
        end
    end

    // Write-only pulse: never stored, so it reads zero and clears at once
    logic       soft_load_bit;
    assign soft_load_bit = wr_at(dac_load_regs_pkg::SOFTWARE_LOAD_TRIGGER_OFS)
                           && req.wdata[dac_load_regs_pkg::CTRL_BIT];

    logic       hw_load;
    assign hw_load = strobe_prev && !strobe_sync && !strobe_mask_bit;

    logic       load_now;
    assign load_now = soft_load_bit || hw_load || auto_sync;

    // ------------------------------------------------------------------
    // Code registers
    // ------------------------------------------------------------------
    logic [15:0] input_page;
    logic [15:0] output_page;
    logic [15:0] pending_code;
    logic [15:0] live_output_code;

    always_ff @(posedge clk_i or negedge resetn) begin
        if (!resetn) begin
            input_page <= dac_load_regs_pkg::CODE_RESET;
        end else if (wr_at(dac_load_regs_pkg::INPUT_PAGE_BROADCAST_OFS)) begin
            input_page <= wcode;
        end
    end

    always_ff @(posedge clk_i or negedge resetn) begin
        if (!resetn) begin
            output_page <= dac_load_regs_pkg::CODE_RESET;
        end else if (wr_at(dac_load_regs_pkg::OUTPUT_PAGE_BROADCAST_OFS)) begin
            output_page <= wcode;
        end
    end

    // Page write with select set wins over a direct write in the same cycle
    always_ff @(posedge clk_i or negedge resetn) begin
        if (!resetn) begin
            pending_code <= dac_load_regs_pkg::CODE_RESET;
        end else if (wr_at(dac_load_regs_pkg::INPUT_PAGE_BROADCAST_OFS)
                     && first_channel_pick) begin
            pending_code <= wcode;
        end else if (wr_at(dac_load_regs_pkg::CHANNEL_INPUT_CODE_OFS)) begin
            pending_code <= wcode;
        end
    end

    // A software write to the output code beats a load in the same cycle
    always_ff @(posedge clk_i or negedge resetn) begin
        if (!resetn) begin
            live_output_code <= dac_load_regs_pkg::CODE_RESET;
        end else if (wr_at(dac_load_regs_pkg::OUTPUT_PAGE_BROADCAST_OFS)
                     && first_channel_pick) begin
            live_output_code <= wcode;
        end else if (wr_at(dac_load_regs_pkg::CHANNEL_OUTPUT_CODE_OFS)) begin
            live_output_code <= wcode;
        end else if (load_now) begin
            live_output_code <= pending_code;
        end
    end

    assign live_output_code_o = live_output_code;

    // ------------------------------------------------------------------
    // Read port, data one cycle after the strobe
    // ------------------------------------------------------------------
    logic [23:0] next_rdata;

    always_comb begin
        next_rdata = dac_load_regs_pkg::READ_ZERO;
        unique case (req.addr)
            dac_load_regs_pkg::PAGE_CHANNEL_SELECT_OFS:
                next_rdata[0] = first_channel_pick;
            dac_load_regs_pkg::STROBE_MASK_REGISTER_OFS:
                next_rdata[0] = strobe_mask_bit;
            dac_load_regs_pkg::INPUT_PAGE_BROADCAST_OFS:
                next_rdata = {input_page, 8'h00};
            dac_load_regs_pkg::OUTPUT_PAGE_BROADCAST_OFS:
                next_rdata = {output_page, 8'h00};
            dac_load_regs_pkg::CHANNEL_INPUT_CODE_OFS:
                next_rdata = {pending_code, 8'h00};
            dac_load_regs_pkg::CHANNEL_OUTPUT_CODE_OFS:
                next_rdata = {live_output_code, 8'h00};
            default:
                next_rdata = dac_load_regs_pkg::READ_ZERO;
        endcase
    end

    // Read data only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or negedge resetn) begin
        if (!resetn) begin
            rdata_o <= dac_load_regs_pkg::READ_ZERO;
        end else if (req.read) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= dac_load_regs_pkg::READ_ZERO;
        end
    end

endmodule

// ===== verif/precision_dac_load_regs_monitor.sv
// Port-level checker of the precision load register bank
`timescale 1ns/10ps
module precision_dac_load_regs_monitor (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        supply_good_i,
    input  wire logic        load_strobe_n_i,
    input  wire logic        auto_transfer_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [23:0] wdata_i,
    input  wire logic        write_i,
    input  wire logic        read_i,
    input  wire logic [23:0] rdata_o,
    input  wire logic [15:0] live_output_code_o
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // Supply loss holds the bank in reset, so checks pause with it
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i || !supply_good_i);
    a_rdata_idle_zero: assert property (!$past(read_i) |-> rdata_o == 24'h000000)
        else $error("read data not zero outside a read answer");
    a_trigger_reads_zero: assert property (read_i && addr_i == 8'h45
        |=> rdata_o == 24'h000000)
        else $error("software load register read back nonzero");
    a_select_high_zero: assert property (read_i && addr_i == 8'h41
        |=> rdata_o[23:1] == 23'h0)
        else $error("select register reserved bits nonzero");
    a_code_low_byte: assert property (read_i && addr_i inside {8'h38, 8'h42, 8'h46}
        |=> rdata_o[7:0] == 8'h00)
        else $error("code register low byte nonzero");
    a_soft_load_moves: assert property (write_i && addr_i == 8'h46 ##1 !write_i ##1
        write_i && addr_i == 8'h45 && wdata_i[0]
        |=> live_output_code_o == $past(wdata_i[23:8], 3))
        else $error("software load did not move input code");
    a_zero_write_noop: assert property ((load_strobe_n_i && !auto_transfer_i)[*5] ##0
        (write_i && addr_i == 8'h45 && !wdata_i[0]) |=> $stable(live_output_code_o))
        else $error("zero write to load register changed output");
    a_unmapped_zero: assert property (read_i && addr_i == 8'h00 |=> rdata_o == 24'h000000)
        else $error("unmapped read nonzero");
    a_output_readback: assert property (read_i && addr_i == 8'h38
        |=> rdata_o[23:8] == $past(live_output_code_o))
        else $error("output code read differs from live code");
    c_soft_load: cover property (write_i && addr_i == 8'h45 && wdata_i[0]);
    c_page_write: cover property (write_i && addr_i == 8'h42);
    c_strobe_fall: cover property ($fell(load_strobe_n_i));
endmodule

bind precision_dac_load_regs precision_dac_load_regs_monitor mon (.clk_i(clk_i),
    .resetn_i(resetn_i), .supply_good_i(supply_good_i), .load_strobe_n_i(load_strobe_n_i),
    .auto_transfer_i(auto_transfer_i), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
    .read_i(read_i), .rdata_o(rdata_o), .live_output_code_o(live_output_code_o));

// ===== verif/precision_dac_load_regs_tb.sv
// Self-checking testbench of the precision load register bank
`timescale 1ns/10ps
module precision_dac_load_regs_tb;
    logic        clk_i, resetn_i, supply_good_i, load_strobe_n_i, auto_transfer_i;
    logic        write_i, read_i;
    logic [7:0]  addr_i;
    logic [23:0] wdata_i, rdata_o;
    logic [15:0] live_output_code_o;
    int          errors, n_tests, cyc;

    precision_dac_load_regs uut (.clk_i(clk_i), .resetn_i(resetn_i),
        .supply_good_i(supply_good_i), .load_strobe_n_i(load_strobe_n_i),
        .auto_transfer_i(auto_transfer_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
        .live_output_code_o(live_output_code_o));

    // ------------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        write_i <= 1'h1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        write_i <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        read_i <= 1'h1;
        addr_i <= a;
        @(posedge clk_i);
        read_i <= 1'h0;
        @(negedge clk_i);
        chk(rdata_o, e);
        @(posedge clk_i);
    endtask
    task automatic lv(input logic [15:0] e);
        @(negedge clk_i);
        chk({live_output_code_o, 8'h00}, {e, 8'h00});
        @(posedge clk_i);
    endtask
    // Pin is synchronised, so the pulse is held well past the two-cycle minimum
    task automatic pulse;
        load_strobe_n_i <= 1'h0;
        repeat (4) @(posedge clk_i);
        load_strobe_n_i <= 1'h1;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic final_report;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_fields;
        wr(8'h46, 24'h1234FF);
        rd(8'h46, 24'h123400);
        wr(8'h41, 24'h0000FF);
        rd(8'h41, 24'h000001);
        wr(8'h45, 24'h0000FE);
        lv(16'h0000);
        rd(8'h45, 24'h000000);
        rd(8'h00, 24'h000000);
        $display("t_fields done");
    endtask
    task automatic t_soft;
        wr(8'h46, 24'hABCD00);
        wr(8'h45, 24'h000001);
        lv(16'hABCD);
        wr(8'h46, 24'hBEEF00);
        repeat (3) @(posedge clk_i);
        lv(16'hABCD);
        $display("t_soft done");
    endtask
    task automatic t_page;
        wr(8'h42, 24'h5A5A00);
        rd(8'h46, 24'h5A5A00);
        rd(8'h42, 24'h5A5A00);
        wr(8'h3E, 24'h777700);
        lv(16'h7777);
        wr(8'h41, 24'h000000);
        wr(8'h42, 24'h111100);
        rd(8'h46, 24'h5A5A00);
        $display("t_page done");
    endtask
    task automatic t_load;
        wr(8'h37, 24'h000001);
        pulse();
        lv(16'h7777);
        wr(8'h37, 24'h000000);
        pulse();
        lv(16'h5A5A);
        wr(8'h38, 24'h4444FF);
        rd(8'h38, 24'h444400);
        wr(8'h46, 24'h333300);
        auto_transfer_i <= 1'h1;
        repeat (6) @(posedge clk_i);
        auto_transfer_i <= 1'h0;
        lv(16'h3333);
        $display("t_load done");
    endtask
    // Mid-run supply loss must clear the bank and release it again
    task automatic t_supply;
        wr(8'h41, 24'h000001);
        rd(8'h41, 24'h000001);
        supply_good_i <= 1'h0;
        repeat (6) @(posedge clk_i);
        lv(16'h0000);
        supply_good_i <= 1'h1;
        repeat (6) @(posedge clk_i);
        rd(8'h41, 24'h000000);
        rd(8'h42, 24'h000000);
        rd(8'h46, 24'h000000);
        lv(16'h0000);
        wr(8'h46, 24'h2222FF);
        wr(8'h45, 24'h000001);
        lv(16'h2222);
        $display("t_supply done");
    endtask

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        {resetn_i, supply_good_i, auto_transfer_i, write_i, read_i} = 5'h00;
        {addr_i, wdata_i, cyc, errors, n_tests} = '0;
        load_strobe_n_i = 1'h1;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        wr(8'h46, 24'h999900);
        supply_good_i <= 1'h1;
        repeat (6) @(posedge clk_i);
        rd(8'h46, 24'h000000);
        rd(8'h41, 24'h000000);
        rd(8'h42, 24'h000000);
        rd(8'h38, 24'h000000);
        $display("t_reset done");
        t_fields();
        t_soft();
        t_page();
        t_load();
        t_supply();
        final_report();
    end
endmodule
